/* hdl/hbsc_top.sv */
// h-bridge spi control: spi slave, register set, bridge drive
`timescale 1ns/1ps
`default_nettype none
`include "hbsc_map.svh"

// Notes on behaviour
// - never both switches of one half-bridge on together
// - direction inputs pick the switch pair: hs_a+ls_b, hs_b+ls_a, both low, both high
// - direction change drops outgoing switches first, dead time before raising, no shoot-through
// - wake low tri-states all four drivers, sleep; high enables
// - disable high tri-states drivers, standby not sleep; low no inhibit
// - slew timing comes from the programmed configuration register
// - spi slave, daisy-chainable on one shared chip select
// - mosi sampled on sclk fall, miso updated on sclk rise
// - miso sends each word msb first, lsb last
// - first received mosi bit is msb, last is lsb
// - after sixteen reply bits, miso echoes mosi until deselect
// - miso high impedance unless chip select low
// - chip select rise applies shifted word to addressed register
// - chip select fall preloads previously addressed register
// - fault flag pulled low for any fault enabled by mask
module hbsc_top
   import hbsc_pkg::*;
(
   // system clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // spi pins
   input wire logic spi_clk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_o,
   // control pins
   input wire logic wake_enable_i,
   input wire logic output_disable_i,
   input wire logic direction_in_a_i,
   input wire logic direction_in_b_i,
   // fault events and open-drain fault flag
   input wire logic [7:0] fault_event_i,
   input wire logic fault_flag_n_i,
   output logic fault_flag_n_o,
   output logic fault_flag_n_oe_o,
   // bridge drive
   output var hbsc_gate_t gate_o,
   output logic [2:0] slew_sel_o,
   output var hbsc_mode_t mode_o
);

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------

   // target switches for a direction pair while active
   function automatic hbsc_gate_t dir_gates(input logic a, input logic b);
      hbsc_gate_t g;
      g = '0;
      case ({a, b})
         2'b10: begin
            g.hs_a = 1'b1;
            g.ls_b = 1'b1;
         end
         2'b01: begin
            g.hs_b = 1'b1;
            g.ls_a = 1'b1;
         end
         2'b00: begin
            g.ls_a = 1'b1;
            g.ls_b = 1'b1;
         end
         default: begin
            g.hs_a = 1'b1;
            g.hs_b = 1'b1;
         end
      endcase
      return g;
   endfunction

   // dead time scaled by the slew setting
   function automatic logic [7:0] dead_len(input logic [2:0] slew);
      logic [7:0] base;
      base = 8'(`HBSC_DEAD_CYC);
      return 8'(base * ({5'h00, slew} + 8'h01));
   endfunction

   // ----------------------------------------------------------------
   // link domain, clocked by the spi clock
   // ----------------------------------------------------------------

   logic [4:0] cnt_r;
   hbsc_lneg_t lneg_r;
   hbsc_lneg_t lneg_nxt;
   logic miso_r;
   hbsc_sys_t s_r;
   hbsc_sys_t s_nxt;

   // bit counter, cleared while deselected, saturates at a full word
   always_ff @(negedge spi_clk_i or posedge spi_cs_n_i) begin
      if (spi_cs_n_i) begin
         cnt_r <= `HBSC_CNT_ZERO;
      end else if (cnt_r != `HBSC_CNT_FULL) begin
         cnt_r <= cnt_r + 5'h01;
      end
   end

   // shift in mosi at lsb; first bit slides in behind the preloaded word
   always_comb begin
      lneg_nxt = lneg_r;
      if (cnt_r == `HBSC_CNT_ZERO) begin
         lneg_nxt.sh = {s_r.reply[`HBSC_WORD_BITS-2:0], spi_mosi_i};
         lneg_nxt.ok = 1'b0;
      end else begin
         lneg_nxt.sh = {lneg_r.sh[`HBSC_WORD_BITS-2:0], spi_mosi_i};
      end
      if (cnt_r == `HBSC_CNT_LAST) begin
         lneg_nxt.ok = 1'b1;
      end
   end

   // falling edge register, sampled only while selected
   always_ff @(negedge spi_clk_i) begin
      if (!spi_cs_n_i) begin
         lneg_r <= lneg_nxt;
      end
   end

   // miso: reply msb first, then the shifted word, i.e. echoed mosi
   always_ff @(posedge spi_clk_i or posedge spi_cs_n_i) begin
      if (spi_cs_n_i) begin
         miso_r <= 1'b0;
      end else if (cnt_r == `HBSC_CNT_ZERO) begin
         miso_r <= s_r.reply[`HBSC_WORD_BITS-1];
      end else begin
         miso_r <= lneg_r.sh[`HBSC_WORD_BITS-1];
      end
   end

   // miso driven only while selected
   assign spi_miso_o = miso_r;
   assign spi_miso_oe_o = ~spi_cs_n_i;

   // ----------------------------------------------------------------
   // system domain
   // ----------------------------------------------------------------

   logic cs_fall;
   logic cs_rise;
   logic [1:0] w_addr;
   logic [7:0] w_data;
   hbsc_gate_t tgt;
   hbsc_gate_t off_now;
   hbsc_gate_t on_now;

   // chip select edges after synchronising
   assign cs_fall = s_r.cs_d & ~s_r.cs_s;
   assign cs_rise = ~s_r.cs_d & s_r.cs_s;
   // received word fields, stable once the frame has ended
   assign w_addr = lneg_r.sh[`HBSC_ADDR_HI:`HBSC_ADDR_LO];
   assign w_data = lneg_r.sh[`HBSC_DATA_HI:0];

   // mode and switch targets
   always_comb begin
      tgt = '0;
      case (s_r.mode)
         HBSC_SLEEP: tgt = '0;
         HBSC_STANDBY: tgt = '0;
         HBSC_ACTIVE: begin
            tgt = dir_gates(s_r.ctl_s.direction_in_a, s_r.ctl_s.direction_in_b);
         end
         default: tgt = '0;
      endcase
   end

   // switches to drop and to raise this cycle
   assign off_now = s_r.gate & ~tgt;
   assign on_now = tgt & ~s_r.gate;

   // next system state
   always_comb begin
      s_nxt = s_r;
      // two-stage synchronisers on chip select, control, fault event and flag pins
      s_nxt.cs_m = spi_cs_n_i;
      s_nxt.cs_s = s_r.cs_m;
      s_nxt.cs_d = s_r.cs_s;
      s_nxt.ok_m = lneg_r.ok;
      s_nxt.ok_s = s_r.ok_m;
      s_nxt.ctl_m = {wake_enable_i, output_disable_i, direction_in_a_i, direction_in_b_i};
      s_nxt.ctl_s = s_r.ctl_m;
      s_nxt.flt_m = fault_event_i;
      s_nxt.flt_s = s_r.flt_m;
      s_nxt.line_m = fault_flag_n_i;
      s_nxt.line_s = s_r.line_m;
      // operating mode from wake and disable
      if (!s_r.ctl_s.wake_enable) begin
         s_nxt.mode = HBSC_SLEEP;
      end else if (s_r.ctl_s.output_disable) begin
         s_nxt.mode = HBSC_STANDBY;
      end else begin
         s_nxt.mode = HBSC_ACTIVE;
      end
      // preload reply for the frame now starting
      if (cs_fall) begin
         if (s_r.prev_addr == `HBSC_A_STATUS) begin
            s_nxt.reply = {s_r.prev_addr, 5'h00, ~s_r.line_s, s_r.status};
         end else if (s_r.prev_addr == `HBSC_A_CONFIG) begin
            s_nxt.reply = {s_r.prev_addr, 11'h000, s_r.slew};
         end else if (s_r.prev_addr == `HBSC_A_MASK) begin
            s_nxt.reply = {s_r.prev_addr, 6'h00, s_r.mask};
         end else begin
            s_nxt.reply = {s_r.prev_addr, 14'h0000};
         end
      end
      // apply a complete word when the frame closes
      if (cs_rise && s_r.ok_s) begin
         s_nxt.prev_addr = w_addr;
         if (w_addr == `HBSC_A_STATUS) begin
            s_nxt.status = s_r.status & ~w_data;
         end else if (w_addr == `HBSC_A_CONFIG) begin
            s_nxt.slew = w_data[`HBSC_SLEW_HI:0];
         end else if (w_addr == `HBSC_A_MASK) begin
            s_nxt.mask = w_data;
         end
      end
      // new faults win over a clear in the same cycle
      s_nxt.status = s_nxt.status | s_r.flt_s;
      // switch sequencing: drop first, raise after dead time
      if (s_r.dead != 8'h00) begin
         s_nxt.dead = s_r.dead - 8'h01;
      end
      if (off_now != '0) begin
         s_nxt.gate = s_r.gate & tgt;
         s_nxt.dead = dead_len(s_r.slew);
      end else if (on_now != '0 && s_r.dead == 8'h00) begin
         s_nxt.gate = tgt;
      end
   end

   // system state register
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s_r <= '0;
         s_r.cs_m <= 1'b1;
         s_r.cs_s <= 1'b1;
         s_r.cs_d <= 1'b1;
         s_r.line_m <= 1'b1;
         s_r.line_s <= 1'b1;
         s_r.status <= `HBSC_FAULT_RST;
         s_r.slew <= `HBSC_SLEW_RST;
         s_r.mask <= `HBSC_MASK_RST;
         s_r.prev_addr <= `HBSC_A_STATUS;
         s_r.mode <= HBSC_SLEEP;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------

   // open-drain flag: only ever drives low
   assign fault_flag_n_o = 1'b0;
   assign fault_flag_n_oe_o = |(s_r.status & s_r.mask);
   assign gate_o = s_r.gate;
   assign slew_sel_o = s_r.slew;
   assign mode_o = s_r.mode;

endmodule // hbsc_top
`default_nettype wire

/* shared/hbsc_map.svh */
// constant map for the h-bridge spi control block
`ifndef HBSC_MAP_SVH
`define HBSC_MAP_SVH
// ----------------------------------------------------------------
// spi word layout
// ----------------------------------------------------------------
`define HBSC_WORD_BITS 16
`define HBSC_CNT_FULL 5'h10
`define HBSC_CNT_LAST 5'h0F
`define HBSC_CNT_ZERO 5'h00
`define HBSC_ADDR_HI 15
`define HBSC_ADDR_LO 14
`define HBSC_DATA_HI 7
`define HBSC_LINE_BIT 8
// ----------------------------------------------------------------
// internal register addresses and reset values
// ----------------------------------------------------------------
`define HBSC_A_STATUS 2'h0
`define HBSC_A_CONFIG 2'h1
`define HBSC_A_MASK 2'h2
`define HBSC_SLEW_HI 2
`define HBSC_SLEW_RST 3'h2
`define HBSC_MASK_RST 8'hFF
`define HBSC_FAULT_RST 8'h00
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HBSC_CLK_NS 4
`define HBSC_DEAD_NS 100
`define HBSC_DEAD_CYC ((`HBSC_DEAD_NS + `HBSC_CLK_NS - 1) / `HBSC_CLK_NS)
`endif

/* shared/hbsc_pkg.sv */
// types shared by the h-bridge spi control block
`default_nettype none
`include "hbsc_map.svh"
package hbsc_pkg;
   // switch drive per half-bridge
   typedef struct packed {
      logic hs_a;
      logic ls_a;
      logic hs_b;
      logic ls_b;
   } hbsc_gate_t;
   // bridge operating mode
   typedef enum logic [1:0] {HBSC_SLEEP, HBSC_STANDBY, HBSC_ACTIVE} hbsc_mode_t;
   // pins synchronised into the system clock
   typedef struct packed {
      logic wake_enable;
      logic output_disable;
      logic direction_in_a;
      logic direction_in_b;
   } hbsc_ctl_t;
   // system clock state
   typedef struct packed {
      logic cs_m;
      logic cs_s;
      logic cs_d;
      logic ok_m;
      logic ok_s;
      hbsc_ctl_t ctl_m;
      hbsc_ctl_t ctl_s;
      logic [7:0] flt_m;
      logic [7:0] flt_s;
      logic line_m;
      logic line_s;
      logic [7:0] status;
      logic [2:0] slew;
      logic [7:0] mask;
      logic [1:0] prev_addr;
      logic [`HBSC_WORD_BITS-1:0] reply;
      hbsc_gate_t gate;
      logic [7:0] dead;
      hbsc_mode_t mode;
   } hbsc_sys_t;
   // link state on the falling edge
   typedef struct packed {
      logic [`HBSC_WORD_BITS-1:0] sh;
      logic ok;
   } hbsc_lneg_t;
endpackage
`default_nettype wire

/* verification/hbsc_host.sv */
// spi master model for the link pins
`timescale 1ns/1ps
`default_nettype none
module hbsc_host (
   // link pins
   output logic spi_clk_o,
   output logic spi_cs_n_o,
   output logic spi_mosi_o,
   input wire logic spi_miso_i
);
   // clock idles low, chip select high
   // one short select pulse at start so the link counter and miso start cleared
   initial begin
      spi_clk_o = 1'b0;
      spi_cs_n_o = 1'b0;
      spi_mosi_o = 1'b0;
      #1 spi_cs_n_o = 1'b1;
   end
   // one 32-bit frame on the shared select, msb first both ways
   task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
      spi_cs_n_o = 1'b0;
      #23.3;
      for (int i = 31; i >= 0; i--) begin
         spi_clk_o = 1'b1;
         #1 spi_mosi_o = tx[i];
         #5 rx[i] = spi_miso_i;
         spi_clk_o = 1'b0;
         #6;
      end
      spi_cs_n_o = 1'b1;
      spi_mosi_o = ~spi_mosi_o; // released line shows no stale bit
      #41.7;
   endtask
endmodule // hbsc_host
`default_nettype wire

/* verification/hbsc_top_assertions.sv */
// concurrent checks on the h-bridge spi control ports
`timescale 1ns/1ps
`default_nettype none
module hbsc_top_assertions
   import hbsc_pkg::*;
(
   // all ports of the top module
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic spi_clk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   input wire logic spi_miso_o,
   input wire logic spi_miso_oe_o,
   input wire logic wake_enable_i,
   input wire logic output_disable_i,
   input wire logic direction_in_a_i,
   input wire logic direction_in_b_i,
   input wire logic [7:0] fault_event_i,
   input wire logic fault_flag_n_i,
   input wire logic fault_flag_n_o,
   input wire logic fault_flag_n_oe_o,
   input wire hbsc_gate_t gate_o,
   input wire logic [2:0] slew_sel_o,
   input wire hbsc_mode_t mode_o
);
   // ----
   // properties
   // ----
   logic [3:0] g;
   assign g = gate_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_no_shoot_a: assert property (!(gate_o.hs_a && gate_o.ls_a))
      else $error("half-bridge a cross conduction");
   a_no_shoot_b: assert property (!(gate_o.hs_b && gate_o.ls_b))
      else $error("half-bridge b cross conduction");
   a_dead_gap: assert property (($past(g) & ~g) != 4'h0 |=> ((g & ~$past(g)) == 4'h0) [*8])
      else $error("switch raised too soon after a drop");
   a_idle_off: assert property ((mode_o != HBSC_ACTIVE) [*2] |-> g == 4'h0)
      else $error("switch on outside active mode");
   a_miso_sel: assert property (spi_miso_oe_o == !spi_cs_n_i)
      else $error("miso enable does not follow select");
   a_miso_quiet: assert property (spi_cs_n_i |-> spi_miso_o == 1'b0)
      else $error("miso active while deselected");
   a_slew_on_cs: assert property ($changed(slew_sel_o) |-> spi_cs_n_i && $past(spi_cs_n_i, 3))
      else $error("slew changed inside a frame");
   a_flag_drive: assert property (fault_flag_n_oe_o |-> fault_flag_n_o == 1'b0)
      else $error("fault flag driven high");
   a_flag_clear: assert property ($fell(fault_flag_n_oe_o) |-> spi_cs_n_i)
      else $error("fault flag released inside a frame");
endmodule // hbsc_top_assertions
bind hbsc_top hbsc_top_assertions hbsc_top_assertions_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .spi_clk_i(spi_clk_i), .spi_cs_n_i(spi_cs_n_i), .spi_mosi_i(spi_mosi_i),
   .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .wake_enable_i(wake_enable_i),
   .output_disable_i(output_disable_i), .direction_in_a_i(direction_in_a_i),
   .direction_in_b_i(direction_in_b_i), .fault_event_i(fault_event_i),
   .fault_flag_n_i(fault_flag_n_i), .fault_flag_n_o(fault_flag_n_o),
   .fault_flag_n_oe_o(fault_flag_n_oe_o), .gate_o(gate_o), .slew_sel_o(slew_sel_o),
   .mode_o(mode_o));
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the h-bridge spi control block
`timescale 1ns/1ps
`default_nettype none
`include "hbsc_map.svh"
module tb;
   import hbsc_pkg::*;
   logic clk_i, sys_rst_i, wake, dis, dir_a, dir_b;
   logic miso, miso_oe, flag_o, flag_oe;
   wire logic spi_clk, spi_cs_n, spi_mosi, miso_w, flag_w;
   logic [7:0] fault_ev;
   logic [2:0] slew;
   hbsc_gate_t gate;
   hbsc_mode_t mode;
   int fail_count = 0;
   int checks_done = 0;
   // pin resolution: miso floats, flag pulled up
   assign miso_w = miso_oe ? miso : 1'bz;
   assign flag_w = flag_oe ? flag_o : 1'b1;
   hbsc_top hbsc_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_clk_i(spi_clk),
      .spi_cs_n_i(spi_cs_n), .spi_mosi_i(spi_mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
      .wake_enable_i(wake), .output_disable_i(dis), .direction_in_a_i(dir_a),
      .direction_in_b_i(dir_b), .fault_event_i(fault_ev), .fault_flag_n_i(flag_w),
      .fault_flag_n_o(flag_o), .fault_flag_n_oe_o(flag_oe), .gate_o(gate),
      .slew_sel_o(slew), .mode_o(mode));
   hbsc_host hbsc_host_i (.spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n), .spi_mosi_o(spi_mosi),
      .spi_miso_i(miso_w));
   // ----
   // helpers
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // order: wake, disable, direction a, direction b
   task automatic pins(input logic [3:0] v);
      @(posedge clk_i) {wake, dis, dir_a, dir_b} <= v;
   endtask
   task automatic frame(input logic [15:0] w, input logic [15:0] exp);
      logic [31:0] rx;
      hbsc_host_i.xfer({16'hA5C3, w}, rx);
      chk(rx[31:16], exp);
      chk(rx[15:0], 16'hA5C3);
      tick(10);
   endtask
   task automatic finish_test();
      if (fail_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_bridge();
      int n;
      pins(4'b1010);
      tick(10);
      chk(gate, 4'b1001);
      chk(mode, HBSC_ACTIVE);
      pins(4'b1001);
      for (n = 0; n < 20 && gate !== 4'h0; n++) tick(1);
      for (n = 0; n < 200 && gate !== 4'b0110; n++) tick(1);
      // slew 2: three base spans of dead time, raise on the cycle after it runs out
      chk(n, 32'(3 * `HBSC_DEAD_CYC + 1));
      // brake low, then brake high, each through the dead time
      pins(4'b1000);
      tick(90);
      chk(gate, 4'b0101);
      pins(4'b1011);
      tick(90);
      chk(gate, 4'b1010);
      pins(4'b1101);
      tick(10);
      chk({gate, mode}, {4'h0, HBSC_STANDBY});
      pins(4'b0110);
      tick(10);
      chk({gate, mode}, {4'h0, HBSC_SLEEP});
   endtask
   task automatic t_spi();
      frame(16'h4005, 16'h0000);
      chk(slew, 3'h5);
      frame(16'hC000, 16'h4005);
      frame(16'h8000, 16'hC000);
      @(posedge clk_i) fault_ev <= 8'h01;
      tick(10);
      chk(flag_w, 1'b1);
      frame(16'h80FF, 16'h8000);
      chk(flag_w, 1'b0);
      @(posedge clk_i) fault_ev <= 8'h00;
      frame(16'h0000, 16'h80FF);
      frame(16'h0001, 16'h0101);
      chk(flag_w, 1'b1);
   endtask
   // clock, main sequence and watchdog
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      sys_rst_i = 1'b1;
      {wake, dis, dir_a, dir_b} = 4'h0;
      fault_ev = 8'h00;
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      tick(6);
      chk(slew, 3'h2);
      t_bridge();
      t_spi();
      finish_test();
   end
   initial begin
      #20000;
      fail_count++;
      finish_test();
   end
endmodule // tb
`default_nettype wire
